// *** logic/rail_order_pkg.sv ***
// Constants for the rail ordering and soft-start controller.
// Assumes a 100 MHz clock and a register port driven by the serial
// management front end on the same clock.
package rail_order_pkg;

    // Channel numbering: 0..3 converters 1..4, 4..11 linear 1..8
    localparam int          NUM_CH       = 12;
    localparam int          PRIO_W       = 4;
    localparam logic [3:0]  PRIO_OFF     = 4'h0;
    localparam logic [3:0]  PRIO_FIRST   = 4'h1;
    localparam logic [3:0]  PRIO_LAST    = 4'hc;

    // Register offsets
    localparam logic [7:0]  ADDR_CONV34  = 8'h2c;
    localparam logic [7:0]  ADDR_LIN12   = 8'h2e;
    localparam logic [7:0]  ADDR_LIN34   = 8'h2f;
    localparam logic [7:0]  ADDR_LIN56   = 8'h30;
    localparam logic [7:0]  ADDR_LIN78   = 8'h31;
    localparam logic [7:0]  ADDR_SS_CTRL = 8'h32;

    // Reset values of the order and soft-start registers
    localparam logic [7:0]  ORDER_RESET  = 8'h00;
    localparam logic [5:0]  SS_RESET     = 6'h00;
    localparam logic [1:0]  SS_FIXED_DEF = 2'h0;

    // Soft-start control field layout
    localparam int          SS_MODE_LSB  = 0;
    localparam int          SS_END_LSB   = 2;
    localparam int          SS_FIX_LSB   = 6;

    // Soft-start modes
    localparam logic [1:0]  MODE_LEVEL   = 2'h0;
    localparam logic [1:0]  MODE_1MS     = 2'h1;
    localparam logic [1:0]  MODE_4MS     = 2'h2;

    // End-control codes
    localparam logic [3:0]  END_FIRST    = 4'h0;
    localparam logic [3:0]  END_CONV1_HI = 4'h4;
    localparam logic [3:0]  END_LIN1     = 4'h5;
    localparam logic [3:0]  END_LIN8     = 4'hc;
    localparam logic [3:0]  CH_CONV1     = 4'h0;
    localparam logic [3:0]  CH_LIN1      = 4'h4;
    localparam logic [3:0]  CH_LIN8      = 4'hb;

    // Turn-on intervals
    localparam int          CLK_NS       = 10;
    localparam int          TSS_1MS_NS   = 1000000;
    localparam int          TSS_4MS_NS   = 4000000;
    localparam int          TSS_8MS_NS   = 8000000;
    localparam int          TSS_1MS_CYC  = (TSS_1MS_NS + CLK_NS - 1) / CLK_NS;
    localparam int          TSS_4MS_CYC  = (TSS_4MS_NS + CLK_NS - 1) / CLK_NS;
    localparam int          TSS_8MS_CYC  = (TSS_8MS_NS + CLK_NS - 1) / CLK_NS;
    localparam int          TMR_W        = 20;

endpackage : rail_order_pkg

// *** logic/order_reg_bank.sv ***
// Register bank holding the priorities of channels 2..11 and soft-start control.
// Assumes single-cycle write and read strobes from the serial front end
// on the same clock; read data appear one cycle after the read strobe.
`timescale 1ns/1ps
module order_reg_bank #(
    parameter logic [1:0] SS_FIXED = rail_order_pkg::SS_FIXED_DEF
) (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        ce,
    input  wire logic [7:0]  reg_addr,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [7:0]  reg_wdata,
    output logic      [7:0]  reg_rdata,
    output logic      [39:0] prio_vec,
    output logic      [5:0]  ss_ctrl
);

    logic [7:0] conv34_q, conv34_d;
    logic [7:0] lin12_q,  lin12_d;
    logic [7:0] lin34_q,  lin34_d;
    logic [7:0] lin56_q,  lin56_d;
    logic [7:0] lin78_q,  lin78_d;
    logic [5:0] ss_q,     ss_d;
    logic [7:0] rdata_q,  rdata_d;

    // Write decode and registered read mux
    always_comb begin
        conv34_d = conv34_q;
        lin12_d  = lin12_q;
        lin34_d  = lin34_q;
        lin56_d  = lin56_q;
        lin78_d  = lin78_q;
        ss_d     = ss_q;
        rdata_d  = rdata_q;
        if (reg_wr) begin
            case (reg_addr)
                rail_order_pkg::ADDR_CONV34:  conv34_d = reg_wdata;
                rail_order_pkg::ADDR_LIN12:   lin12_d  = reg_wdata;
                rail_order_pkg::ADDR_LIN34:   lin34_d  = reg_wdata;
                rail_order_pkg::ADDR_LIN56:   lin56_d  = reg_wdata;
                rail_order_pkg::ADDR_LIN78:   lin78_d  = reg_wdata;
                rail_order_pkg::ADDR_SS_CTRL: ss_d = reg_wdata[5:0];
                default:                      ;
            endcase
        end
        if (reg_rd) begin
            case (reg_addr)
                rail_order_pkg::ADDR_CONV34:  rdata_d = conv34_q;
                rail_order_pkg::ADDR_LIN12:   rdata_d = lin12_q;
                rail_order_pkg::ADDR_LIN34:   rdata_d = lin34_q;
                rail_order_pkg::ADDR_LIN56:   rdata_d = lin56_q;
                rail_order_pkg::ADDR_LIN78:   rdata_d = lin78_q;
                rail_order_pkg::ADDR_SS_CTRL:
                    rdata_d = {SS_FIXED, ss_q};
                default:                      rdata_d = 8'h00;
            endcase
        end
    end

    // State registers, frozen while ce is low
    always_ff @(posedge clk) begin
        if (rst) begin
            conv34_q <= rail_order_pkg::ORDER_RESET;
            lin12_q  <= rail_order_pkg::ORDER_RESET;
            lin34_q  <= rail_order_pkg::ORDER_RESET;
            lin56_q  <= rail_order_pkg::ORDER_RESET;
            lin78_q  <= rail_order_pkg::ORDER_RESET;
            ss_q     <= rail_order_pkg::SS_RESET;
            rdata_q  <= 8'h00;
        end else if (ce) begin
            conv34_q <= conv34_d;
            lin12_q  <= lin12_d;
            lin34_q  <= lin34_d;
            lin56_q  <= lin56_d;
            lin78_q  <= lin78_d;
            ss_q     <= ss_d;
            rdata_q  <= rdata_d;
        end
    end

    // Fields laid out as channels 2..11, four bits each
    assign prio_vec  = {lin78_q, lin56_q, lin34_q, lin12_q, conv34_q};
    assign ss_ctrl   = ss_q;
    assign reg_rdata = rdata_q;

endmodule : order_reg_bank

// *** logic/rail_order_softstart_ctrl.sv ***
// Rail ordering and soft-start controller: steps channel enables up in
// priority order and down in reverse, and flags the power-good reference.
// Assumes level detectors and pin-side controls arrive asynchronously;
// converter 1 and 2 priorities come from logic on the same clock.
`timescale 1ns/1ps
module rail_order_softstart_ctrl #(
    parameter int unsigned TSS1_CYCLES = rail_order_pkg::TSS_1MS_CYC,
    parameter int unsigned TSS4_CYCLES = rail_order_pkg::TSS_4MS_CYC,
    parameter int unsigned TSS8_CYCLES = rail_order_pkg::TSS_8MS_CYC
) (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        ce,
    input  wire logic [7:0]  reg_addr,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [7:0]  reg_wdata,
    output logic      [7:0]  reg_rdata,
    input  wire logic [7:0]  conv12_priority,
    input  wire logic        seq_on,
    input  wire logic        enable_src_i2c,
    input  wire logic [11:0] level_ok,
    output logic      [11:0] chan_en,
    output logic             power_good_ref_done,
    output logic             seq_busy
);

    typedef enum logic [2:0] {
        S_OFF,
        S_UP_STEP,
        S_UP_WAIT,
        S_ON,
        S_DN_STEP,
        S_DN_WAIT
    } seq_state_t;

    logic [39:0] prio_hi;
    logic [47:0] prio_all;
    logic [5:0]  ss_ctrl;
    logic [1:0]  mode;
    logic [3:0]  end_code;

    // Registers reached from the serial front end
    order_reg_bank u_regs (
        .clk       (clk),
        .rst       (rst),
        .ce        (ce),
        .reg_addr  (reg_addr),
        .reg_wr    (reg_wr),
        .reg_rd    (reg_rd),
        .reg_wdata (reg_wdata),
        .reg_rdata (reg_rdata),
        .prio_vec  (prio_hi),
        .ss_ctrl   (ss_ctrl)
    );

    assign prio_all = {prio_hi, conv12_priority};
    assign mode     = ss_ctrl[rail_order_pkg::SS_MODE_LSB +: 2];
    assign end_code = ss_ctrl[rail_order_pkg::SS_END_LSB +: 4];

    // Channels whose priority equals the given step
    function automatic logic [11:0] group_mask(input logic [47:0] pv,
                                               input logic [3:0]  step);
        logic [11:0] m;
        m = 12'h000;
        for (int i = 0; i < rail_order_pkg::NUM_CH; i++) begin
            m[i] = (pv[i*rail_order_pkg::PRIO_W +: 4] == step);
        end
        return m;
    endfunction : group_mask

    // One-hot reference channel for an end-control code
    function automatic logic [11:0] ref_onehot(input logic [3:0] code);
        logic [3:0] ch;
        ch = rail_order_pkg::CH_CONV1;
        if (code >= rail_order_pkg::END_LIN8) begin
            ch = rail_order_pkg::CH_LIN8;
        end else if (code >= rail_order_pkg::END_LIN1) begin
            ch = 4'(code - rail_order_pkg::END_LIN1 +
                    rail_order_pkg::CH_LIN1);
        end
        return 12'(12'h001 << ch);
    endfunction : ref_onehot

    // Two-flop synchronisers for pin-side inputs
    logic [13:0] sync1_q, sync2_q;
    always_ff @(posedge clk) begin
        if (rst) begin
            sync1_q <= 14'h0000;
            sync2_q <= 14'h0000;
        end else if (ce) begin
            sync1_q <= {enable_src_i2c, seq_on, level_ok};
            sync2_q <= sync1_q;
        end
    end

    logic [11:0] lvl_s;
    logic        on_s;
    logic        i2c_s;
    assign lvl_s = sync2_q[11:0];
    assign on_s  = sync2_q[12];
    assign i2c_s = sync2_q[13];

    seq_state_t              state_q,  state_d;
    logic [3:0]              step_q,   step_d;
    logic [11:0]             en_q,     en_d;
    logic [11:0]             first_q,  first_d;
    logic [rail_order_pkg::TMR_W-1:0] tmr_q, tmr_d;
    logic                    pg_q,     pg_d;
    logic                    busy_q,   busy_d;
    logic [11:0]             mask;
    logic [11:0]             ref_mask;
    logic [rail_order_pkg::TMR_W-1:0] tss_last;
    logic                    tmr_done;

    // Interval length for the selected timed mode
    always_comb begin
        case (mode)
            rail_order_pkg::MODE_1MS:
                tss_last = rail_order_pkg::TMR_W'(TSS1_CYCLES - 1);
            rail_order_pkg::MODE_4MS:
                tss_last = rail_order_pkg::TMR_W'(TSS4_CYCLES - 1);
            default:
                tss_last = rail_order_pkg::TMR_W'(TSS8_CYCLES - 1);
        endcase
    end

    assign mask     = group_mask(prio_all, step_q);
    assign tmr_done = (tmr_q >= tss_last);

    // Sequencer next-state logic
    always_comb begin
        state_d = state_q;
        step_d  = step_q;
        en_d    = en_q;
        first_d = first_q;
        tmr_d   = tmr_q;
        case (state_q)
            S_OFF: begin
                if (on_s) begin
                    step_d  = rail_order_pkg::PRIO_FIRST;
                    state_d = S_UP_STEP;
                end
            end
            S_UP_STEP: begin
                if (!on_s) begin
                    step_d  = rail_order_pkg::PRIO_LAST;
                    state_d = S_DN_STEP;
                end else if (mask == 12'h000) begin
                    if (step_q == rail_order_pkg::PRIO_LAST) begin
                        state_d = S_ON;
                    end else begin
                        step_d = step_q + 4'h1;
                    end
                end else begin
                    en_d  = en_q | mask;
                    tmr_d = '0;
                    if (first_q == 12'h000) begin
                        first_d = mask;
                    end
                    state_d = S_UP_WAIT;
                end
            end
            S_UP_WAIT: begin
                if ((mode == rail_order_pkg::MODE_LEVEL)
                        ? ((lvl_s & mask) == mask)
                        : tmr_done) begin
                    if (step_q == rail_order_pkg::PRIO_LAST) begin
                        state_d = S_ON;
                    end else begin
                        step_d  = step_q + 4'h1;
                        state_d = S_UP_STEP;
                    end
                end else begin
                    tmr_d = tmr_q + 1'b1;
                end
            end
            S_ON: begin
                if (!on_s) begin
                    step_d  = rail_order_pkg::PRIO_LAST;
                    state_d = S_DN_STEP;
                end
            end
            S_DN_STEP: begin
                if ((mask & en_q) == 12'h000) begin
                    if (step_q == rail_order_pkg::PRIO_FIRST) begin
                        en_d    = 12'h000;
                        first_d = 12'h000;
                        state_d = S_OFF;
                    end else begin
                        step_d = step_q - 4'h1;
                    end
                end else begin
                    en_d    = en_q & ~mask;
                    tmr_d   = '0;
                    state_d = S_DN_WAIT;
                end
            end
            S_DN_WAIT: begin
                if ((mode == rail_order_pkg::MODE_LEVEL)
                        ? ((lvl_s & mask) == 12'h000)
                        : tmr_done) begin
                    if (step_q == rail_order_pkg::PRIO_FIRST) begin
                        en_d    = 12'h000;
                        first_d = 12'h000;
                        state_d = S_OFF;
                    end else begin
                        step_d  = step_q - 4'h1;
                        state_d = S_DN_STEP;
                    end
                end else begin
                    tmr_d = tmr_q + 1'b1;
                end
            end
            default: begin
                state_d = S_OFF;
                en_d    = 12'h000;
            end
        endcase
    end

    // Power-good reference selection and status
    always_comb begin
        if (i2c_s || (end_code == rail_order_pkg::END_FIRST)) begin
            ref_mask = first_q;
        end else begin
            ref_mask = ref_onehot(end_code);
        end
        pg_d   = (state_d == S_ON) && ((ref_mask & en_q & lvl_s) != 12'h000);
        busy_d = (state_d != S_OFF) && (state_d != S_ON);
    end

    // Sequencer registers, frozen while ce is low
    always_ff @(posedge clk) begin
        if (rst) begin
            state_q <= S_OFF;
            step_q  <= rail_order_pkg::PRIO_OFF;
            en_q    <= 12'h000;
            first_q <= 12'h000;
            tmr_q   <= '0;
            pg_q    <= 1'b0;
            busy_q  <= 1'b0;
        end else if (ce) begin
            state_q <= state_d;
            step_q  <= step_d;
            en_q    <= en_d;
            first_q <= first_d;
            tmr_q   <= tmr_d;
            pg_q    <= pg_d;
            busy_q  <= busy_d;
        end
    end

    assign chan_en             = en_q;
    assign power_good_ref_done = pg_q;
    assign seq_busy            = busy_q;

endmodule : rail_order_softstart_ctrl

// *** testbench/rail_order_chk_sva.sv ***
// Checker for the rail ordering controller, bound to its top module.
// Assumes order and mode registers change only while all rails are off.
`timescale 1ns/1ps
module rail_order_chk #(
    parameter int unsigned TSS1_CYCLES = 5,
    parameter int unsigned TSS4_CYCLES = 10,
    parameter int unsigned TSS8_CYCLES = 20
) (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        ce,
    input wire logic [7:0]  reg_addr,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [7:0]  reg_wdata,
    input wire logic [7:0]  reg_rdata,
    input wire logic [7:0]  conv12_priority,
    input wire logic        seq_on,
    input wire logic        enable_src_i2c,
    input wire logic [11:0] level_ok,
    input wire logic [11:0] chan_en,
    input wire logic        power_good_ref_done,
    input wire logic        seq_busy
);
    logic [7:0]  shd_q [6];
    logic [3:0]  pr [12];
    logic [11:0] en_q, rose, fell, ok;
    logic [3:0]  mx_prev, mn_rose, mx_on, mn_fell;
    logic [31:0] gap_q, turn_on_interval;
    logic [7:0]  rd_exp;
    logic [1:0]  mode;
    int          ix;

    // Shadow registers, last enables, cycles since the last turn-on
    always_ff @(posedge clk) begin
        if (rst) begin
            for (int k = 0; k < 6; k++)
                shd_q[k] <= 8'h00;
            en_q  <= 12'h000;
            gap_q <= 32'h0000ffff;
        end else if (ce) begin
            if (reg_wr && ix >= 0)
                shd_q[ix] <= reg_wdata;
            en_q  <= chan_en;
            gap_q <= (|rose) ? 32'h0 : gap_q + 32'h1;
        end
    end

    // Expected read data, priorities and group bounds
    always_comb begin
        ix = -1;
        if (reg_addr == 8'h2c)
            ix = 0;
        else if (reg_addr >= 8'h2e && reg_addr <= 8'h32)
            ix = int'(reg_addr - 8'h2d);
        rd_exp = 8'h00;
        if (ix >= 0)
            rd_exp = shd_q[ix];
        if (ix == 5)
            rd_exp[7:6] = 2'h0;
        mode = shd_q[5][1:0];
        turn_on_interval = (mode == 2'h1) ? TSS1_CYCLES :
              (mode == 2'h2) ? TSS4_CYCLES : TSS8_CYCLES;
        rose = chan_en & ~en_q;
        fell = en_q & ~chan_en;
        {mx_prev, mx_on} = 8'h00;
        {mn_rose, mn_fell} = 8'hff;
        for (int i = 0; i < 12; i++) begin
            pr[i] = (i < 2) ? conv12_priority[4*i +: 4]
                            : shd_q[i/2 - 1][4*(i%2) +: 4];
            ok[i] = pr[i] != 4'h0 && pr[i] <= 4'hc;
            if (en_q[i] && pr[i] > mx_prev) mx_prev = pr[i];
            if (chan_en[i] && pr[i] > mx_on) mx_on = pr[i];
            if (rose[i] && pr[i] < mn_rose) mn_rose = pr[i];
            if (fell[i] && pr[i] < mn_fell) mn_fell = pr[i];
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence rd_req;
        ce && reg_rd;
    endsequence
    sequence ss_rd;
        rd_req ##0 (reg_addr == 8'h32);
    endsequence

    read_data_a:
        assert property (rd_req |=> reg_rdata == $past(rd_exp))
        else $error("read data differs from the written value");
    rdata_hold_a:
        assert property (!(ce && reg_rd) |=> $stable(reg_rdata))
        else $error("read data moved without a read");
    fixed_bits_a:
        assert property (ss_rd |=> reg_rdata[7:6] == 2'h0)
        else $error("soft-start top bits not fixed");
    prio_gate_a:
        assert property ((chan_en & ~ok) == 12'h000)
        else $error("channel on with an off or unused priority");
    up_order_a:
        assert property (|rose |-> mx_prev < mn_rose)
        else $error("turn-on out of priority order");
    down_order_a:
        assert property (|fell |-> mx_on < mn_fell)
        else $error("turn-off out of reverse order");
    level_wait_a:
        assert property (mode == 2'h0 && |rose
                         |-> ($past(level_ok, 2) & en_q) == en_q)
        else $error("next channel on before outputs reached level");
    timed_gap_a:
        assert property (mode != 2'h0 && |rose |-> gap_q >= turn_on_interval)
        else $error("turn-on interval too short");
    pg_on_a:
        assert property (power_good_ref_done |-> !seq_busy && |chan_en)
        else $error("power good flag outside the on state");
endmodule : rail_order_chk

// *** testbench/rail_level_model.sv ***
// Far-side model: output level detectors of the twelve channels.
// Assumes enables from the controller; the lag is chosen per run.
`timescale 1ns/1ps
module rail_level_model (
    input  wire logic        clk,
    input  wire logic [11:0] chan_en,
    input  wire logic [3:0]  lag,
    output logic      [11:0] level_ok
);
    logic [3:0] cnt_q [12] = '{default: 4'h0};

    // Each detector follows its enable after the lag, up and down
    initial level_ok = 12'h000;
    always @(posedge clk) begin
        for (int i = 0; i < 12; i++) begin
            if (chan_en[i] === level_ok[i]) begin
                cnt_q[i] <= 4'h0;
            end else if (cnt_q[i] >= lag) begin
                level_ok[i] <= chan_en[i];
                cnt_q[i]    <= 4'h0;
            end else begin
                cnt_q[i] <= cnt_q[i] + 4'h1;
            end
        end
    end
endmodule : rail_level_model

// *** testbench/rail_order_softstart_ctrl_tb.sv ***
// Self-checking bench for the rail ordering and soft-start controller.
// Assumes turn-on intervals shortened to 5, 10 and 20 cycles.
`timescale 1ns/1ps
module rail_order_softstart_ctrl_tb;
    localparam int unsigned T1 = 5;
    localparam int unsigned T4 = 10;
    localparam int unsigned T8 = 20;
    logic        clk, rst, ce, reg_wr, reg_rd, seq_on, src, pg, busy;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata, c12, got, ss;
    logic [11:0] level_ok, chan_en, en_p;
    logic [3:0]  lag;
    logic [3:0]  pr [12];
    logic [7:0]  adr [7] = '{8'h2c, 8'h2e, 8'h2f, 8'h30, 8'h31, 8'h32,
                             8'h33};
    int          seed = 32;
    int          cyc, miscompares, n_tests;
    int          t_on [12];
    int          t_off [12];

    rail_order_softstart_ctrl #(.TSS1_CYCLES(T1), .TSS4_CYCLES(T4),
        .TSS8_CYCLES(T8)) rail_order_softstart_ctrl_i (
        .clk(clk), .rst(rst), .ce(ce), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .conv12_priority(c12), .seq_on(seq_on),
        .enable_src_i2c(src), .level_ok(level_ok), .chan_en(chan_en),
        .power_good_ref_done(pg), .seq_busy(busy));
    rail_level_model rail_level_model_i (.clk(clk), .chan_en(chan_en),
        .lag(lag), .level_ok(level_ok));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Turn-on and turn-off times of every channel, and the hang guard
    always @(posedge clk) begin
        cyc++;
        for (int i = 0; i < 12; i++) begin
            if (chan_en[i] === 1'b1 && !en_p[i]) t_on[i] = cyc;
            if (chan_en[i] === 1'b0 && en_p[i]) t_off[i] = cyc;
        end
        en_p = chan_en;
        if (cyc > 40000) begin
            miscompares++;
            stop_test();
        end
    end

    task automatic chk(input string nm, input logic [31:0] seen, exp);
        n_tests++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, d);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        @(posedge clk);
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] q);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(posedge clk);
        q = reg_rdata;
    endtask : rd

    function automatic logic ok_p(input logic [3:0] p);
        return p != 4'h0 && p <= 4'hc;
    endfunction : ok_p

    // Power-good reference must be a channel that was turned on
    function automatic logic pg_exp(input logic [3:0] c, input logic s);
        logic any;
        any = 1'b0;
        for (int i = 0; i < 12; i++)
            any |= ok_p(pr[i]);
        if (s || c == 4'h0) return any;
        if (c <= 4'h4) return ok_p(pr[0]);
        if (c >= 4'hc) return ok_p(pr[11]);
        return ok_p(pr[c - 4'h1]);
    endfunction : pg_exp

    // Level mode: detector lag, two sync stages and two sequencer steps
    function automatic int gap(input logic [1:0] m);
        return (m == 2'h0) ? int'(lag) + 5 : (m == 2'h1) ? T1 + 1 :
               (m == 2'h2) ? T4 + 1 : T8 + 1;
    endfunction : gap

    task automatic wait_idle();
        repeat (8) @(posedge clk);
        while (busy !== 1'b0) @(posedge clk);
        repeat (24) @(posedge clk);
    endtask : wait_idle

    // One power-up and power-down with random priorities
    task automatic run(input int r);
        for (int i = 0; i < 12; i++)
            pr[i] = 4'($random(seed));
        if (r % 3 == 0) pr[r % 12] = 4'hd;
        if (r % 3 == 1) pr[5] = pr[4];
        ss = {2'h3, r[3:0], r[1:0]};
        c12 <= {pr[1], pr[0]};
        src <= (r > 15);
        lag <= 4'($random(seed));
        wr(8'h2c, {pr[3], pr[2]});
        for (int k = 0; k < 4; k++)
            wr(8'(8'h2e + k), {pr[5 + 2*k], pr[4 + 2*k]});
        wr(8'h32, ss);
        seq_on <= 1'b1;
        repeat (4) @(posedge clk);
        chk("busy", busy, 1'b1);
        wait_idle();
        chk("power good", pg, pg_exp(r[3:0], r > 15));
        for (int i = 0; i < 12; i++)
            chk("channel enable", chan_en[i], ok_p(pr[i]));
        seq_on <= 1'b0;
        wait_idle();
        for (int i = 0; i < 12; i++)
            for (int j = 0; j < 12; j++)
                if (ok_p(pr[i]) && ok_p(pr[j]) && pr[i] < pr[j]) begin
                    chk("on spacing", t_on[j] - t_on[i] >= gap(r[1:0]),
                        1);
                    chk("off order", t_off[i] > t_off[j], 1);
                end else if (ok_p(pr[i]) && pr[i] == pr[j])
                    chk("same step", t_on[i], t_on[j]);
        $display("sequence test %0d done", r);
    endtask : run

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : stop_test

    initial begin
        {rst, reg_wr, reg_rd, seq_on, src, ce} = 6'h21;
        {reg_addr, reg_wdata, c12, lag} = 28'h0;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        // Reset values and the unmapped place
        for (int a = 0; a < 7; a++) begin
            rd(adr[a], got);
            chk("reset value", got, 8'h00);
        end
        // A write while the clock enable is low must not land
        ce <= 1'b0;
        wr(8'h2f, 8'h5a);
        ce <= 1'b1;
        rd(8'h2f, got);
        chk("frozen write", got, 8'h00);
        // Random write and read back; soft-start top bits stay fixed
        for (int a = 0; a < 7; a++) begin
            ss = 8'($random(seed));
            wr(adr[a], ss);
            rd(adr[a], got);
            chk("read back", got, (a == 6) ? 8'h00 : (a == 5) ?
                {2'h0, ss[5:0]} : ss);
        end
        $display("register test done");
        for (int r = 0; r < 18; r++)
            run(r);
        stop_test();
    end
endmodule : rail_order_softstart_ctrl_tb

bind rail_order_softstart_ctrl rail_order_chk #(.TSS1_CYCLES(TSS1_CYCLES),
    .TSS4_CYCLES(TSS4_CYCLES), .TSS8_CYCLES(TSS8_CYCLES)) rail_order_chk_i (
    .clk(clk), .rst(rst), .ce(ce), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .conv12_priority(conv12_priority), .seq_on(seq_on),
    .enable_src_i2c(enable_src_i2c), .level_ok(level_ok),
    .chan_en(chan_en), .power_good_ref_done(power_good_ref_done),
    .seq_busy(seq_busy));
